/* File: bench/ttx_exec_assertions.sv */
`default_nettype none
module ttx_exec_assertions
  import ttx_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] src_val_i,
  input wire logic [15:0] dst_val_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic [15:0] frame_pointer_i,
  input wire logic [15:0] cpu_flag_word_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic reg_we_o,
  input wire logic [15:0] reg_wdata_o,
  input wire logic sp_we_o,
  input wire logic [15:0] sp_wdata_o,
  input wire logic flag_we_o,
  input wire logic [15:0] cpu_flag_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go;
  logic [7:0] op;
  // A request counts only while the sequencer is idle
  assign go = start_i && !busy_o;
  assign op = opcode_i[15:8];
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  // ********
  // Checks
  // ********
  a_xnor_word:
    assert property (go && op == OP_XNOR_W |-> reg_we_o && reg_wdata_o == ~(src_val_i ^ dst_val_i))
    else $error("xnor word");
  a_xnor_byte:
    assert property (go && op == OP_XNOR_B |-> reg_wdata_o == {HIGH_ONES, ~(src_val_i[7:0] ^ dst_val_i[7:0])})
    else $error("xnor byte");
  a_unarrow_carry:
    assert property (go && op == OP_UNARROW |-> flag_we_o && cpu_flag_word_o[FLAG_C] == (|dst_val_i[15:8]))
    else $error("unsigned carry");
  a_snarrow_ovf:
    assert property (go && op == OP_SNARROW |-> cpu_flag_word_o[FLAG_V] == !(&dst_val_i[15:7] || ~|dst_val_i[15:7]))
    else $error("signed overflow");
  a_flag_push:
    assert property (go && op == OP_VCALL_HI |=> mem_req_o && mem_we_o && mem_addr_o == $past(stack_pointer_i)
      && mem_wdata_o == $past(cpu_flag_word_i))
    else $error("flag push");
  a_level_ones:
    assert property (flag_we_o && busy_o |-> cpu_flag_word_o[LVL_HI:LVL_LO] == 3'h7
      && cpu_flag_word_o[3:0] == cpu_flag_word_i[3:0])
    else $error("level bits");
  a_release_sp:
    assert property (go && op == OP_RELEASE |=> sp_we_o && sp_wdata_o == $past(frame_pointer_i))
    else $error("release pointer");
  a_release_gap:
    assert property (go && op == OP_RELEASE |=> (!flag_we_o && !done_o)[*2] ##[1:30] done_o)
    else $error("release timing");
  c_trap: cover property (go && op == OP_VCALL_HI);
  c_release: cover property (go && op == OP_RELEASE);
  c_xnor_byte: cover property (go && op == OP_XNOR_B);
endmodule
bind ttx_exec ttx_exec_assertions ttx_exec_assertions_inst (.clock_i, .resetn_i, .start_i, .busy_o,
  .done_o, .opcode_i, .src_val_i, .dst_val_i, .stack_pointer_i, .frame_pointer_i, .cpu_flag_word_i,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .reg_we_o, .reg_wdata_o, .sp_we_o, .sp_wdata_o,
  .flag_we_o, .cpu_flag_word_o);
`default_nettype wire

/* File: bench/ttx_exec_tb_top.sv */
`default_nettype none
module ttx_exec_tb_top
  import ttx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, resetn_i, start_i, mem_ready_i, busy_o, done_o, mem_req_o, mem_we_o;
  logic reg_we_o, sp_we_o, pc_we_o, flag_we_o;
  logic [15:0] opcode_i, src_val_i, dst_val_i, ext_val_i, stack_pointer_i, frame_pointer_i;
  logic [15:0] program_counter_i, cpu_flag_word_i, mem_rdata_i, mem_addr_o, mem_wdata_o;
  logic [15:0] reg_wdata_o, sp_wdata_o, pc_wdata_o, cpu_flag_word_o;
  logic [3:0] reg_idx_o, mem_wait;
  logic [16:0] fetch_addr_o;
  int fails = 0;
  int total_checks = 0;
  ttx_exec #(.VEC_BASE(16'h0100)) ttx_exec_inst (.clock_i, .resetn_i, .start_i, .opcode_i,
    .src_val_i, .dst_val_i, .ext_val_i, .stack_pointer_i, .frame_pointer_i, .program_counter_i,
    .cpu_flag_word_i, .mem_rdata_i, .mem_ready_i, .busy_o, .done_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .reg_we_o, .reg_idx_o, .reg_wdata_o, .sp_we_o, .sp_wdata_o, .pc_we_o, .pc_wdata_o,
    .fetch_addr_o, .flag_we_o, .cpu_flag_word_o);
  ttx_mem_model ttx_mem_model_inst (.clock_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .wait_i(mem_wait), .ready_o(mem_ready_i), .rdata_o(mem_rdata_i));
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Single-cycle op: answer is combinational in the start cycle
  task automatic one(input logic [15:0] op, s, d, x, r, input logic [3:0] f);
    @(posedge clock_i);
    start_i <= 1'h1;
    opcode_i <= op;
    src_val_i <= s;
    dst_val_i <= d;
    ext_val_i <= x;
    @(negedge clock_i);
    chk({busy_o, done_o, flag_we_o, cpu_flag_word_o}, {3'h3, 12'h000, f});
    if (op[15:9] == 7'h16)
      chk({reg_we_o, reg_idx_o, reg_wdata_o}, {1'h1, op[3:0], r});
    if (op[15:9] == 7'h01)
      chk({reg_we_o, reg_idx_o, reg_wdata_o}, {1'h1, REG_ZERO, r});
  endtask
  // Multi-cycle op: watch every sp, pc, register and flag write pulse until done, under a bound
  task automatic seq(input logic [15:0] op, sp, v, input logic [3:0] w, input int cyc, n);
    int c;
    int k;
    c = 0;
    k = 0;
    @(posedge clock_i);
    mem_wait <= w;
    start_i <= 1'h1;
    opcode_i <= op;
    @(posedge clock_i);
    start_i <= 1'h0;
    while (c < 40 && done_o !== 1'h1)
    begin
      @(negedge clock_i);
      c++;
      chk(busy_o, 1'h1);
      k = k + int'(sp_we_o) + int'(pc_we_o) + int'(reg_we_o) + int'(flag_we_o);
      if (sp_we_o) chk(sp_wdata_o, sp);
      if (pc_we_o) chk(pc_wdata_o, v);
      if (reg_we_o) chk({reg_idx_o, reg_wdata_o}, {REG_FRAME, v});
      if (flag_we_o) chk(cpu_flag_word_o, 16'h007C);
    end
    chk(done_o, 1'h1);
    if (op[15:8] == OP_VCALL_HI) chk(fetch_addr_o, {v, 1'h0});
    if (cyc != 0) chk(c, cyc);
    chk(k, n);
  endtask
  initial
  begin
    clock_i = 1'h0;
    forever #20 clock_i = ~clock_i;
  end
  // Hang guard, far beyond the few dozen cycles the tests need
  initial
  begin
    repeat (2000) @(posedge clock_i);
    fails++;
    report_and_stop();
  end
  initial
  begin
    {resetn_i, start_i, opcode_i, src_val_i, dst_val_i, ext_val_i, mem_wait} = '0;
    {stack_pointer_i, frame_pointer_i} = {16'h0300, 16'h0310};
    {program_counter_i, cpu_flag_word_i} = {16'h1234, 16'h000C};
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    one(16'h2C3B, 16'h00F0, 16'h0FF0, 16'h0000, 16'hF0FF, 4'h6);
    one(16'h2D3B, 16'h12A5, 16'h34A5, 16'h0000, 16'hFFFF, 4'h6);
    one(16'h2D3B, 16'h00FF, 16'h0000, 16'h0000, 16'hFF00, 4'h5);
    one(16'hAD02, 16'h0000, 16'h0080, 16'h0000, 16'h0000, 4'h2);
    one(16'hAD02, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 4'h5);
    one(16'hAE02, 16'h0000, 16'hFF80, 16'h0000, 16'h0000, 4'h2);
    one(16'hAE02, 16'h0000, 16'h0080, 16'h0000, 16'h0000, 4'hA);
    one(16'hAE02, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 4'hB);
    one(16'hAF02, 16'h0000, 16'h8000, 16'hFFFF, 16'h0000, 4'h2);
    one(16'hAF02, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 4'h8);
    one(16'h021F, 16'h0000, 16'h1111, 16'h0000, 16'h0000, 4'h5);
    one(16'h021F, 16'h8001, 16'h1111, 16'h0000, 16'h8001, 4'h6);
    one(16'h031F, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 4'h5);
    @(posedge clock_i);
    start_i <= 1'h0;
    $display("single-cycle test ends");
    seq(16'hFFFF, 16'h0304, 16'h4080, 4'h0, 5, 3);
    chk(ttx_mem_model_inst.mem[9'h180], 16'h000C);
    chk(ttx_mem_model_inst.mem[9'h181], 16'h1235);
    seq(16'hFF00, 16'h0304, 16'h417F, 4'h2, 0, 3);
    $display("trap test ends");
    ttx_mem_model_inst.mem[9'h188] = 16'hBEEF;
    seq(16'hF600, 16'h0310, 16'hBEEF, 4'h0, 3, 2);
    $display("release test ends");
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: bench/ttx_mem_model.sv */
`default_nettype none
module ttx_mem_model
(
  input wire logic clock_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] wait_i,
  output logic ready_o,
  output logic [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Memory
  // ********
  logic [15:0] mem [512];
  logic [15:0] last_ff = 16'h0000;
  logic [3:0] cnt_ff = 4'h0;
  // Vector entries hold distinct handler words
  initial for (int i = 0; i < 512; i++) mem[i] = 16'h4000 + 16'(i);
  // Answer after wait_i stall cycles
  assign ready_o = req_i && (cnt_ff == wait_i);
  // An idle bus shows the inverse of the last word, never a stale copy
  assign rdata_o = req_i ? mem[addr_i[9:1]] : ~last_ff;
  // Stall counter and write port
  always @(posedge clock_i)
  begin
    cnt_ff <= (ready_o || !req_i) ? 4'h0 : cnt_ff + 4'h1;
    if (ready_o)
      last_ff <= rdata_o;
    if (ready_o && we_i)
      mem[addr_i[9:1]] <= wdata_i;
  end
endmodule
`default_nettype wire

/* File: hw/ttx_exec.sv */
`default_nettype none
module ttx_exec
  import ttx_pkg::*;
#(
  parameter logic [15:0] VEC_BASE = VEC_BASE_DEF
)
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] src_val_i,
  input wire logic [15:0] dst_val_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic [15:0] frame_pointer_i,
  input wire logic [15:0] program_counter_i,
  input wire logic [15:0] cpu_flag_word_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ready_i,
  output logic busy_o,
  output logic done_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic reg_we_o,
  output logic [3:0] reg_idx_o,
  output logic [15:0] reg_wdata_o,
  output logic sp_we_o,
  output logic [15:0] sp_wdata_o,
  output logic pc_we_o,
  output logic [15:0] pc_wdata_o,
  output logic [16:0] fetch_addr_o,
  output logic flag_we_o,
  output logic [15:0] cpu_flag_word_o
);

  // ************************************************************
  // Reset synchroniser
  // ************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Release reset through two flops so removal is clean
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ************************************************************
  // Single-cycle flag computations
  // ************************************************************
  function automatic logic [15:0] set_zn(input logic [15:0] flags, input logic zero, input logic neg);
    logic [15:0] f;
    f = flags;
    f[FLAG_Z] = zero;
    f[FLAG_N] = neg;
    return f;
  endfunction

  logic [7:0] op_hi;
  logic [7:0] op_lo;
  logic byte_probe;
  logic byte_xnor;
  logic [15:0] xnor_res;
  logic [15:0] probe_val;
  logic snarrow_v;
  logic lnarrow_v;
  logic unarrow_c;
  logic [15:0] vec_addr;

  assign op_hi = opcode_i[15:8];
  assign op_lo = opcode_i[7:0];
  assign byte_probe = (op_hi == OP_PROBE_B);
  assign byte_xnor = (op_hi == OP_XNOR_B);
  // Byte form zero-extends both, so the top byte of the inverse is all ones
  assign xnor_res = byte_xnor ? {HIGH_ONES, ~(src_val_i[7:0] ^ dst_val_i[7:0])}
                              : ~(src_val_i ^ dst_val_i);
  assign probe_val = byte_probe ? {8'h00, src_val_i[7:0]} : src_val_i;
  // Word fits a byte only when bits 7..15 all agree
  assign snarrow_v = !((&dst_val_i[15:7]) || !(|dst_val_i[15:7]));
  // Long fits a word only when extension bits and bit 15 all agree
  assign lnarrow_v = !((&{ext_val_i, dst_val_i[15]}) || !(|{ext_val_i, dst_val_i[15]}));
  assign unarrow_c = |dst_val_i[15:8];
  // Inverted enumerator doubled gives the byte offset into the table
  assign vec_addr = VEC_BASE + {7'h00, ~op_lo, 1'b0};

  // ************************************************************
  // Sequencer
  // ************************************************************
  ttx_state_type state_ff, nxt_state;
  logic [15:0] sp_ff, nxt_sp;
  logic [15:0] addr_ff, nxt_addr;

  // Next state, memory cycles and register writes
  always_comb
  begin
    logic [15:0] f;
    f = cpu_flag_word_i;
    nxt_state = state_ff;
    nxt_sp = sp_ff;
    nxt_addr = addr_ff;
    mem_req_o = 1'b0;
    mem_we_o = 1'b0;
    mem_addr_o = WORD_ZERO;
    mem_wdata_o = WORD_ZERO;
    reg_we_o = 1'b0;
    reg_idx_o = REG_ZERO;
    reg_wdata_o = WORD_ZERO;
    sp_we_o = 1'b0;
    sp_wdata_o = WORD_ZERO;
    pc_we_o = 1'b0;
    pc_wdata_o = WORD_ZERO;
    flag_we_o = 1'b0;
    cpu_flag_word_o = cpu_flag_word_i;
    done_o = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_i)
        begin
          if (op_hi == OP_VCALL_HI)
          begin
            nxt_sp = stack_pointer_i;
            nxt_addr = vec_addr;
            nxt_state = ST_PUSH_FLAG;
          end
          else if (op_hi == OP_RELEASE)
          begin
            nxt_state = ST_REL_GAP;
          end
          else if (op_hi == OP_SNARROW || op_hi == OP_SNARROW_L)
          begin
            f[FLAG_V] = (op_hi == OP_SNARROW_L) ? lnarrow_v : snarrow_v;
            f[FLAG_C] = 1'b0;
            f[FLAG_N] = f[FLAG_V] ^ dst_val_i[15];
            f[FLAG_Z] = (op_hi == OP_SNARROW_L) ? (dst_val_i == WORD_ZERO)
                                                : (dst_val_i[7:0] == 8'h00);
            flag_we_o = 1'b1;
            cpu_flag_word_o = f;
            done_o = 1'b1;
          end
          else if (op_hi == OP_UNARROW)
          begin
            f = set_zn(f, dst_val_i[7:0] == 8'h00, dst_val_i[7]);
            f[FLAG_C] = unarrow_c;
            f[FLAG_V] = 1'b0;
            flag_we_o = 1'b1;
            cpu_flag_word_o = f;
            done_o = 1'b1;
          end
          else if (op_hi == OP_PROBE_W || op_hi == OP_PROBE_B)
          begin
            // Zero register ignores writes, so the copy only moves flags
            reg_we_o = 1'b1;
            reg_idx_o = REG_ZERO;
            reg_wdata_o = probe_val;
            f = set_zn(f, byte_probe ? (probe_val[7:0] == 8'h00) : (probe_val == WORD_ZERO),
                       byte_probe ? probe_val[7] : probe_val[15]);
            f[FLAG_V] = 1'b0;
            flag_we_o = 1'b1;
            cpu_flag_word_o = f;
            done_o = 1'b1;
          end
          else if (op_hi == OP_XNOR_W || byte_xnor)
          begin
            reg_we_o = 1'b1;
            reg_idx_o = opcode_i[3:0];
            reg_wdata_o = xnor_res;
            f = set_zn(f, byte_xnor ? (xnor_res[7:0] == 8'h00) : (xnor_res == WORD_ZERO),
                       byte_xnor ? xnor_res[7] : xnor_res[15]);
            f[FLAG_V] = 1'b0;
            flag_we_o = 1'b1;
            cpu_flag_word_o = f;
            done_o = 1'b1;
          end
          else
          begin
            done_o = 1'b1;
          end
        end
      end
      ST_PUSH_FLAG:
      begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b1;
        mem_addr_o = sp_ff;
        mem_wdata_o = cpu_flag_word_i;
        if (mem_ready_i)
        begin
          nxt_sp = sp_ff + STACK_STEP;
          nxt_state = ST_PUSH_RET;
        end
      end
      ST_PUSH_RET:
      begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b1;
        mem_addr_o = sp_ff;
        mem_wdata_o = program_counter_i + RET_STEP;
        if (mem_ready_i)
        begin
          nxt_sp = sp_ff + STACK_STEP;
          nxt_state = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // Idle bus cycle; table address was captured at start, so a new opcode cannot steer it
        sp_we_o = 1'b1;
        sp_wdata_o = sp_ff;
        nxt_state = ST_VEC_RD;
      end
      ST_VEC_RD:
      begin
        mem_req_o = 1'b1;
        mem_addr_o = addr_ff;
        if (mem_ready_i)
        begin
          pc_we_o = 1'b1;
          pc_wdata_o = mem_rdata_i;
          f[LVL_HI:LVL_LO] = 3'b111;
          flag_we_o = 1'b1;
          cpu_flag_word_o = f;
          nxt_addr = mem_rdata_i;
          nxt_state = ST_DONE;
        end
      end
      ST_REL_GAP:
      begin
        // Stack pointer takes the frame pointer; flags are never touched
        sp_we_o = 1'b1;
        sp_wdata_o = frame_pointer_i;
        nxt_addr = frame_pointer_i;
        nxt_state = ST_REL_RD;
      end
      ST_REL_RD:
      begin
        mem_req_o = 1'b1;
        mem_addr_o = addr_ff;
        if (mem_ready_i)
        begin
          reg_we_o = 1'b1;
          reg_idx_o = REG_FRAME;
          reg_wdata_o = mem_rdata_i;
          nxt_addr = program_counter_i;
          nxt_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        done_o = 1'b1;
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clock_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff <= ST_IDLE;
      sp_ff <= WORD_ZERO;
      addr_ff <= WORD_ZERO;
    end
    else
    begin
      state_ff <= nxt_state;
      sp_ff <= nxt_sp;
      addr_ff <= nxt_addr;
    end
  end

  assign busy_o = (state_ff != ST_IDLE);
  // Code addresses are word addresses, so the fetch byte address is doubled
  assign fetch_addr_o = {addr_ff, 1'b0};

endmodule
`default_nettype wire

/* File: inc/ttx_pkg.sv */
`default_nettype none
package ttx_pkg;
  // ************************************************************
  // Opcode encodings
  // ************************************************************
  localparam logic [7:0] OP_VCALL_HI = 8'hFF;
  localparam logic [7:0] OP_SNARROW = 8'hAE;
  localparam logic [7:0] OP_SNARROW_L = 8'hAF;
  localparam logic [7:0] OP_UNARROW = 8'hAD;
  localparam logic [7:0] OP_XNOR_W = 8'h2C;
  localparam logic [7:0] OP_XNOR_B = 8'h2D;
  localparam logic [7:0] OP_RELEASE = 8'hF6;
  localparam logic [7:0] OP_PROBE_W = 8'h02;
  localparam logic [7:0] OP_PROBE_B = 8'h03;
  // ************************************************************
  // Register file indices and flag word fields
  // ************************************************************
  localparam logic [3:0] REG_FRAME = 4'h0;
  localparam logic [3:0] REG_STACK = 4'hD;
  localparam logic [3:0] REG_ZERO = 4'hF;
  localparam int FLAG_Z = 0;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 2;
  localparam int FLAG_V = 3;
  localparam int LVL_LO = 4;
  localparam int LVL_HI = 6;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] RET_STEP = 16'h0001;
  localparam logic [15:0] VEC_BASE_DEF = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] HIGH_ONES = 8'hFF;
  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_FLAG = 3'b001,
    ST_PUSH_RET = 3'b010,
    ST_GAP = 3'b011,
    ST_VEC_RD = 3'b100,
    ST_REL_GAP = 3'b101,
    ST_REL_RD = 3'b110,
    ST_DONE = 3'b111
  } ttx_state_type;
endpackage
`default_nettype wire
